// ### rtl/cbl_defines.vh
// Constants for the CCD digitizer black-level control block
`ifndef CBL_DEFINES_VH
`define CBL_DEFINES_VH

// Register byte addresses
`define CBL_ADDR_CTRL        8'h00
`define CBL_ADDR_GAIN        8'h04
`define CBL_ADDR_TARGET      8'h08
`define CBL_ADDR_CAL         8'h0c
`define CBL_ADDR_RESET       8'h10
`define CBL_ADDR_COARSE      8'h14
`define CBL_ADDR_FINE        8'h18
`define CBL_ADDR_AVERAGE     8'h1c

// Control register fields
`define CBL_CTRL_BYPASS      0
`define CBL_CTRL_CONV_POL    1
`define CBL_CTRL_DRIVE_GATE  2
`define CBL_CTRL_REDUCED     3
`define CBL_CTRL_CONV_DIRECT 4
`define CBL_CTRL_SLEEP       5
`define CBL_CTRL_DAC0_OFF    6
`define CBL_CTRL_DAC1_OFF    7
`define CBL_CTRL_FE_OFF      8
`define CBL_CTRL_CONV_OFF    9
`define CBL_CTRL_W           10

// Calibration register fields
`define CBL_CAL_AVG_LSB      0
`define CBL_CAL_AVG_MSB      2
`define CBL_CAL_HOLD         3

// Reset values
`define CBL_CTRL_RESET       10'h004
`define CBL_GAIN_RESET       10'h000
`define CBL_TARGET_RESET     8'h00
`define CBL_AVG_RESET        3'h5
`define CBL_HOLD_RESET       1'h0

// Gain code saturation point
`define CBL_GAIN_SAT         10'h300
// Clipper ceiling for calibration samples
`define CBL_CLIP_MAX         12'h1ff

// Software reset pulse length
`define CBL_SWRST_NS         10
`define CBL_CLK_NS           50
`define CBL_SWRST_CYC        (((`CBL_SWRST_NS / `CBL_CLK_NS) < 1) ? 1 : (`CBL_SWRST_NS / `CBL_CLK_NS))

`endif

// ### rtl/cbl_control.v
// Control, reset and black-level calibration logic of the CCD digitizer
`timescale 1ns/100ps
`default_nettype none
`include "cbl_defines.vh"

module cbl_control #(
  parameter COARSE_W = 9,
  parameter FINE_W   = 10
) (
  input  wire                sys_clk,
  input  wire                reset_n,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output reg  [31:0]         prdata,
  output reg                 pslverr,
  input  wire                sleep_pin,
  input  wire                output_enable_pin,
  input  wire                reset_pin,
  input  wire                restore_window,
  input  wire                black_window,
  input  wire                black_sample_strobe,
  input  wire                video_sample_strobe,
  input  wire                converter_clock,
  input  wire [11:0]         adc_data,
  input  wire                adc_over,
  input  wire                adc_valid,
  output reg  [9:0]          gain_step,
  output reg                 restore_switch,
  output reg                 sample_black_switch,
  output reg                 sampler_to_amp_en,
  output reg                 test_pins_to_amp_en,
  output reg                 conv_direct_en,
  output reg                 converter_track,
  output reg                 reduced_resolution_bit,
  output reg                 analog_power_en,
  output reg                 front_end_power_en,
  output reg                 converter_power_en,
  output reg                 aux_dac_zero_power_en,
  output reg                 aux_dac_one_power_en,
  output reg  [11:0]         result_bus,
  output reg                 range_flag,
  output reg                 result_bus_oe,
  output reg  [COARSE_W-1:0] coarse_dac,
  output reg  [FINE_W-1:0]   fine_dac
);

  localparam [FINE_W-1:0]   FINE_MID   = {1'b1, {(FINE_W-1){1'b0}}};
  localparam [FINE_W-1:0]   FINE_MAX   = {FINE_W{1'b1}};
  localparam [COARSE_W-1:0] COARSE_MID = {1'b1, {(COARSE_W-1){1'b0}}};
  localparam [COARSE_W-1:0] COARSE_MAX = {COARSE_W{1'b1}};
  localparam                SWRST_CYC_I = `CBL_SWRST_CYC;
  localparam [3:0]          SWRST_CYC   = SWRST_CYC_I[3:0];

  // Pin synchronisers: sleep, oe, reset, restore, black win, blk, vid, conv clk
  wire [7:0] pin_raw;
  reg  [7:0] pin_meta_q;
  reg  [7:0] pin_sync_q;

  assign pin_raw = {converter_clock, video_sample_strobe, black_sample_strobe,
                    black_window, restore_window, reset_pin, output_enable_pin,
                    sleep_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin_sync
      always @(posedge sys_clk) begin
        if (!reset_n) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  wire sleep_s   = pin_sync_q[0];
  wire oe_pin_s  = pin_sync_q[1];
  wire rstpin_s  = pin_sync_q[2];
  wire restore_s = pin_sync_q[3];
  wire blkwin_s  = pin_sync_q[4];
  wire blk_s     = pin_sync_q[5];
  wire vid_s     = pin_sync_q[6];
  wire cclk_s    = pin_sync_q[7];

  // Software reset pulse
  reg  [3:0] swrst_cnt_q;
  reg  [3:0] swrst_cnt_d;
  wire       swrst_active = (swrst_cnt_q != 4'h0);
  wire       chip_rst     = !reset_n || rstpin_s || swrst_active;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;

  always @* begin
    swrst_cnt_d = swrst_cnt_q;
    if (swrst_active)
      swrst_cnt_d = swrst_cnt_q - 4'h1;
    else if (wr_en && paddr == `CBL_ADDR_RESET && pwdata[0])
      swrst_cnt_d = SWRST_CYC;
  end

  always @(posedge sys_clk) begin
    if (!reset_n)
      swrst_cnt_q <= 4'h0;
    else
      swrst_cnt_q <= swrst_cnt_d;
  end

  // Configuration registers
  reg [`CBL_CTRL_W-1:0] ctrl_q;
  reg [9:0]             gain_q;
  reg [7:0]             black_target_code;
  reg [2:0]             avg_code_q;
  reg                   hold_bit_q;

  always @(posedge sys_clk) begin
    if (chip_rst) begin
      ctrl_q            <= `CBL_CTRL_RESET;
      gain_q            <= `CBL_GAIN_RESET;
      black_target_code <= `CBL_TARGET_RESET;
      avg_code_q        <= `CBL_AVG_RESET;
      hold_bit_q        <= `CBL_HOLD_RESET;
    end else if (wr_en) begin
      if (paddr == `CBL_ADDR_CTRL) begin
        ctrl_q <= pwdata[`CBL_CTRL_W-1:0];
      end else if (paddr == `CBL_ADDR_GAIN) begin
        gain_q <= pwdata[9:0];
      end else if (paddr == `CBL_ADDR_TARGET) begin
        black_target_code <= pwdata[7:0];
      end else if (paddr == `CBL_ADDR_CAL) begin
        avg_code_q <= pwdata[`CBL_CAL_AVG_MSB:`CBL_CAL_AVG_LSB];
        hold_bit_q <= pwdata[`CBL_CAL_HOLD];
      end
    end
  end

  wire bypass_sampler_bit         = ctrl_q[`CBL_CTRL_BYPASS];
  wire converter_edge_polarity    = ctrl_q[`CBL_CTRL_CONV_POL];
  wire drive_gate_bit             = ctrl_q[`CBL_CTRL_DRIVE_GATE];
  wire reduced_res                = ctrl_q[`CBL_CTRL_REDUCED];
  wire converter_direct_input_bit = ctrl_q[`CBL_CTRL_CONV_DIRECT];
  wire sleep_bit                  = ctrl_q[`CBL_CTRL_SLEEP];
  wire aux_dac_zero_off           = ctrl_q[`CBL_CTRL_DAC0_OFF];
  wire aux_dac_one_off            = ctrl_q[`CBL_CTRL_DAC1_OFF];
  wire front_end_off              = ctrl_q[`CBL_CTRL_FE_OFF];
  wire converter_off              = ctrl_q[`CBL_CTRL_CONV_OFF];

  // Power-down only gates functions; no register is cleared by it
  wire powerdown = sleep_s || sleep_bit;
  wire cal_hold  = hold_bit_q || reduced_res || powerdown;

  // Gain clamp and sampling switches
  always @(posedge sys_clk) begin
    if (chip_rst) begin
      gain_step           <= 10'h000;
      restore_switch      <= 1'b0;
      sample_black_switch <= 1'b0;
    end else begin
      gain_step           <= (gain_q >= `CBL_GAIN_SAT) ? `CBL_GAIN_SAT : gain_q;
      restore_switch      <= restore_s && vid_s;
      sample_black_switch <= blk_s;
    end
  end

  // Signal path steering; direct converter input wins over bypass
  always @(posedge sys_clk) begin
    if (chip_rst) begin
      sampler_to_amp_en      <= 1'b0;
      test_pins_to_amp_en    <= 1'b0;
      conv_direct_en         <= 1'b0;
      converter_track        <= 1'b0;
      reduced_resolution_bit <= 1'b0;
    end else begin
      sampler_to_amp_en      <= !bypass_sampler_bit && !converter_direct_input_bit;
      test_pins_to_amp_en    <= bypass_sampler_bit && !converter_direct_input_bit;
      conv_direct_en         <= converter_direct_input_bit;
      converter_track        <= cclk_s ^ converter_edge_polarity;
      reduced_resolution_bit <= reduced_res;
    end
  end

  // Section power enables
  always @(posedge sys_clk) begin
    if (chip_rst) begin
      analog_power_en       <= 1'b0;
      front_end_power_en    <= 1'b0;
      converter_power_en    <= 1'b0;
      aux_dac_zero_power_en <= 1'b0;
      aux_dac_one_power_en  <= 1'b0;
    end else begin
      analog_power_en       <= !powerdown;
      front_end_power_en    <= !powerdown && !front_end_off;
      converter_power_en    <= !powerdown && !converter_off;
      aux_dac_zero_power_en <= !powerdown && !aux_dac_zero_off;
      aux_dac_one_power_en  <= !powerdown && !aux_dac_one_off;
    end
  end

  // Result bus: same one-cycle latency in both resolutions
  always @(posedge sys_clk) begin
    if (chip_rst) begin
      result_bus <= 12'h000;
      range_flag <= 1'b0;
    end else if (adc_valid) begin
      result_bus <= reduced_res ? {adc_data[11:6], 6'h00} : adc_data;
      range_flag <= adc_over;
    end
  end

  // Drivers only; nothing else sees the gate
  always @(posedge sys_clk) begin
    if (chip_rst)
      result_bus_oe <= 1'b0;
    else
      result_bus_oe <= drive_gate_bit && oe_pin_s && !powerdown;
  end

  // Hot pixel clipper and averager
  wire [11:0] clipped = (adc_data > `CBL_CLIP_MAX) ? `CBL_CLIP_MAX : adc_data;
  wire        black_px = adc_valid && blkwin_s;
  wire [9:0]  avg_last = (10'h004 << avg_code_q) - 10'h001;

  reg  [17:0] acc_q;
  reg  [9:0]  cnt_q;
  reg  [8:0]  average_q;
  reg         update_q;
  reg  [17:0] acc_d;
  reg  [9:0]  cnt_d;
  reg  [8:0]  average_d;
  reg         update_d;

  wire [17:0] acc_sum = acc_q + {9'h000, clipped[8:0]};
  wire [17:0] avg_shift = acc_sum >> ({1'b0, avg_code_q} + 4'h2);

  // Averaging runs under hold too; only the coarse and fine offset accumulators freeze
  always @* begin
    acc_d     = acc_q;
    cnt_d     = cnt_q;
    average_d = average_q;
    update_d  = 1'b0;
    if (black_px) begin
      if (cnt_q >= avg_last) begin
        acc_d     = 18'h00000;
        cnt_d     = 10'h000;
        average_d = avg_shift[8:0];
        update_d  = 1'b1;
      end else begin
        acc_d = acc_sum;
        cnt_d = cnt_q + 10'h001;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (chip_rst) begin
      acc_q     <= 18'h00000;
      cnt_q     <= 10'h000;
      average_q <= 9'h000;
      update_q  <= 1'b0;
    end else begin
      acc_q     <= acc_d;
      cnt_q     <= cnt_d;
      average_q <= average_d;
      update_q  <= update_d;
    end
  end

  // Offset difference and accumulators
  wire [9:0] diff = {1'b0, average_q} - {2'b00, black_target_code};
  wire       diff_pos = !diff[9] && (diff != 10'h000);
  wire       diff_neg = diff[9];

  reg [COARSE_W-1:0] coarse_d;
  reg [FINE_W-1:0]   fine_d;

  always @* begin
    coarse_d = coarse_dac;
    fine_d   = fine_dac;
    if (update_q && !cal_hold) begin
      if (diff_pos) begin
        if (fine_dac == {FINE_W{1'b0}}) begin
          fine_d = FINE_MID;
          if (coarse_dac != {COARSE_W{1'b0}})
            coarse_d = coarse_dac - 1'b1;
        end else begin
          fine_d = fine_dac - 1'b1;
        end
      end else if (diff_neg) begin
        if (fine_dac == FINE_MAX) begin
          fine_d = FINE_MID;
          if (coarse_dac != COARSE_MAX)
            coarse_d = coarse_dac + 1'b1;
        end else begin
          fine_d = fine_dac + 1'b1;
        end
      end
    end
  end

  always @(posedge sys_clk) begin
    if (chip_rst) begin
      coarse_dac <= COARSE_MID;
      fine_dac   <= FINE_MID;
    end else begin
      coarse_dac <= coarse_d;
      fine_dac   <= fine_d;
    end
  end

  // APB slave: zero wait states, error on unmapped address
  assign pready = 1'b1;

  always @* begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    if (paddr == `CBL_ADDR_CTRL) begin
      prdata = {22'h000000, ctrl_q};
    end else if (paddr == `CBL_ADDR_GAIN) begin
      prdata = {22'h000000, gain_q};
    end else if (paddr == `CBL_ADDR_TARGET) begin
      prdata = {24'h000000, black_target_code};
    end else if (paddr == `CBL_ADDR_CAL) begin
      prdata = {28'h0000000, hold_bit_q, avg_code_q};
    end else if (paddr == `CBL_ADDR_RESET) begin
      prdata = {31'h00000000, swrst_active};
    end else if (paddr == `CBL_ADDR_COARSE) begin
      prdata = {{(32-COARSE_W){1'b0}}, coarse_dac};
    end else if (paddr == `CBL_ADDR_FINE) begin
      prdata = {{(32-FINE_W){1'b0}}, fine_dac};
    end else if (paddr == `CBL_ADDR_AVERAGE) begin
      prdata = {23'h000000, average_q};
    end else begin
      pslverr = psel && penable;
    end
    if (!rd_en)
      prdata = 32'h00000000;
  end

endmodule // cbl_control
`default_nettype wire

// ### testbench/cbl_control_asserts.sv
// Port-level checker for the black-level control block
`timescale 1ns/100ps
`default_nettype none
module cbl_control_asserts #(
  parameter COARSE_W = 9,
  parameter FINE_W   = 10
) (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic                sleep_pin,
  input wire logic                output_enable_pin,
  input wire logic                restore_window,
  input wire logic                video_sample_strobe,
  input wire logic [11:0]         adc_data,
  input wire logic                adc_valid,
  input wire logic                adc_over,
  input wire logic                range_flag,
  input wire logic [9:0]          gain_step,
  input wire logic                restore_switch,
  input wire logic                reduced_resolution_bit,
  input wire logic                analog_power_en,
  input wire logic [11:0]         result_bus,
  input wire logic                result_bus_oe,
  input wire logic [COARSE_W-1:0] coarse_dac,
  input wire logic [FINE_W-1:0]   fine_dac
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_sleep_held;
    sleep_pin [*5];
  endsequence
  sequence s_oe_low_held;
    !output_enable_pin [*4];
  endsequence
  sequence s_full_sample;
    adc_valid && !reduced_resolution_bit ##1 !reduced_resolution_bit;
  endsequence
  a_gain_saturate: assert property (gain_step <= 10'h300)
    else $error("gain step beyond saturation");
  a_restore_and: assert property (restore_switch ==
    ($past(restore_window, 3) && $past(video_sample_strobe, 3)))
    else $error("restore switch not the and of its inputs");
  a_oe_pin_gate: assert property (s_oe_low_held |-> !result_bus_oe)
    else $error("bus driven with enable pin low");
  a_sleep_off: assert property (s_sleep_held |-> !result_bus_oe && !analog_power_en)
    else $error("sleep left bus or analog powered");
  a_sleep_freeze: assert property (s_sleep_held |-> $stable(fine_dac) && $stable(coarse_dac))
    else $error("offset moved in sleep");
  a_bus_unclipped: assert property (s_full_sample |-> result_bus == $past(adc_data))
    else $error("result bus differs from sample");
  a_reduced_low: assert property (reduced_resolution_bit && $past(reduced_resolution_bit)
    && $past(adc_valid) |-> result_bus[5:0] == 6'h00)
    else $error("low bits set in reduced mode");
  a_reduced_hold: assert property (reduced_resolution_bit && $past(reduced_resolution_bit)
    |-> $stable(fine_dac) && $stable(coarse_dac))
    else $error("offset moved in reduced mode");
  a_fine_step: assert property ($changed(fine_dac) |-> fine_dac == 10'h200
    || fine_dac == $past(fine_dac) + 10'h001 || fine_dac == $past(fine_dac) - 10'h001)
    else $error("fine step not one or mid-scale");
  a_coarse_wrap: assert property ($changed(coarse_dac) |-> fine_dac == 10'h200)
    else $error("coarse moved without fine wrap");
  a_range_follow: assert property (adc_valid |=> range_flag == $past(adc_over))
    else $error("range flag not the sampled overflow");
endmodule // cbl_control_asserts
bind cbl_control cbl_control_asserts #(.COARSE_W(COARSE_W), .FINE_W(FINE_W))
  i_cbl_control_asserts (.*);
`default_nettype wire

// ### testbench/cbl_ccd_model.sv
// Sensor and line timing model feeding black pixels
`timescale 1ns/100ps
`default_nettype none
module cbl_ccd_model (
  input  wire logic        sys_clk,
  input  wire logic        model_en,
  input  wire logic [11:0] model_pix,
  output var  logic        black_window,
  output var  logic        adc_valid,
  output var  logic [11:0] adc_data,
  output var  logic        adc_over
);
  logic [3:0] pos_q;
  initial begin
    pos_q = 4'h0;
    black_window = 1'b0;
    adc_valid = 1'b0;
    adc_data = 12'h000;
    adc_over = 1'b0;
  end
  // Lines of 16 samples, first 8 optical black
  always @(posedge sys_clk) begin
    pos_q <= model_en ? pos_q + 4'h1 : 4'h0;
    black_window <= model_en && (pos_q < 4'h8);
    adc_valid <= model_en;
    adc_data <= model_en ? model_pix : ~adc_data;
    adc_over <= model_en && pos_q[3];
  end
endmodule // cbl_ccd_model
`default_nettype wire

// ### testbench/cbl_control_tb.sv
// Self-checking bench for the black-level control block
`timescale 1ns/100ps
`default_nettype none
module cbl_control_tb;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sleep_pin, output_enable_pin, reset_pin, restore_window, black_window;
  logic        black_sample_strobe, video_sample_strobe, converter_clock, adc_over;
  logic        adc_valid, model_en, range_flag, result_bus_oe, restore_switch;
  logic        sample_black_switch, sampler_to_amp_en, test_pins_to_amp_en;
  logic        conv_direct_en, converter_track, reduced_resolution_bit, analog_power_en;
  logic        front_end_power_en, converter_power_en, aux_dac_zero_power_en;
  logic        aux_dac_one_power_en;
  logic [11:0] adc_data, model_pix, result_bus;
  logic [9:0]  gain_step, fine_dac, f0;
  logic [8:0]  coarse_dac;
  int          error_cnt, check_count, n;
  int          gv[4] = '{0, 767, 768, 1023};
  wire logic [4:0] pwr = {aux_dac_zero_power_en, aux_dac_one_power_en,
                          front_end_power_en, converter_power_en, analog_power_en};
  cbl_control i_cbl_control (.*);
  cbl_ccd_model i_cbl_ccd_model (.*);
  always #25 sys_clk = ~sys_clk;
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_fine(input int lim);
    f0 = fine_dac;
    n = 0;
    while (fine_dac === f0 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {sys_clk, psel, penable, pwrite, paddr, pwdata, sleep_pin, reset_pin} = '0;
    {output_enable_pin, restore_window, black_sample_strobe, video_sample_strobe} = '0;
    {converter_clock, model_en, model_pix, reset_n, error_cnt, check_count} = '0;
    cyc(2);
    reset_n <= 1'b1;
    rdc(8'h00, 32'h004);
    rdc(8'h04, 32'h000);
    rdc(8'h0c, 32'h005);
    rdc(8'h14, 32'h100);
    rdc(8'h18, 32'h200);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    foreach (gv[i]) begin
      wr(8'h04, gv[i]);
      cyc(2);
      chk(gain_step, gv[i] > 767 ? 768 : gv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      restore_window <= i[0];
      video_sample_strobe <= i[1];
      black_sample_strobe <= i[0] ^ i[1];
      cyc(4);
      chk(restore_switch, i == 3);
      chk(sample_black_switch, i[0] ^ i[1]);
    end
    restore_window <= 1'b0;
    video_sample_strobe <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h004 | (32'h40 << i));
      cyc(2);
      chk(pwr, 5'h1f & ~(5'h10 >> i));
    end
    wr(8'h0c, 32'h8);
    wr(8'h00, 32'h005);
    cyc(2);
    chk({sampler_to_amp_en, test_pins_to_amp_en}, 2'b01);
    wr(8'h00, 32'h014);
    cyc(2);
    chk({sampler_to_amp_en, test_pins_to_amp_en, conv_direct_en}, 3'b001);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h004 | {i[1], 1'b0});
      @(posedge sys_clk);
      converter_clock <= i[0];
      cyc(4);
      chk(converter_track, i[0] ^ i[1]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {i[0], 2'b00});
      @(posedge sys_clk);
      output_enable_pin <= i[1];
      cyc(4);
      chk(result_bus_oe, i == 3);
    end
    wr(8'h04, 32'h155);
    @(posedge sys_clk);
    sleep_pin <= 1'b1;
    cyc(5);
    chk({result_bus_oe, analog_power_en}, 2'b00);
    rdc(8'h04, 32'h155);
    sleep_pin <= 1'b0;
    cyc(4);
    chk(result_bus_oe, 1'b1);
    wr(8'h00, 32'h024);
    cyc(2);
    chk(result_bus_oe, 1'b0);
    rdc(8'h00, 32'h024);
    wr(8'h10, 32'h1);
    cyc(2);
    rdc(8'h10, 32'h0);
    rdc(8'h00, 32'h004);
    rdc(8'h04, 32'h000);
    wr(8'h08, 32'h64);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h000);
    model_pix <= 12'h258;
    @(posedge sys_clk);
    model_en <= 1'b1;
    wait_fine(200);
    chk(n >= 45 && n <= 80, 1'b1);
    chk(fine_dac, 10'h1ff);
    chk(result_bus_oe, 1'b0);
    chk(result_bus, 12'h258);
    wr(8'h0c, 32'h8);
    cyc(4);
    wait_fine(150);
    chk(n, 150);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h00c);
    cyc(4);
    chk(result_bus, 12'h240);
    wait_fine(150);
    chk(n, 150);
    wr(8'h00, 32'h004);
    n = 0;
    while (coarse_dac === 9'h100 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(fine_dac, 10'h200);
    chk(coarse_dac, 9'h0ff);
    model_en <= 1'b0;
    wr(8'h10, 32'h1);
    cyc(2);
    wr(8'h08, 32'h64);
    model_pix <= 12'h032;
    @(posedge sys_clk);
    model_en <= 1'b1;
    wait_fine(600);
    chk(n >= 230 && n <= 280, 1'b1);
    chk(fine_dac, 10'h201);
    model_en <= 1'b0;
    wr(8'h04, 32'h2aa);
    @(posedge sys_clk);
    reset_pin <= 1'b1;
    cyc(8);
    chk({coarse_dac, fine_dac}, {9'h100, 10'h200});
    reset_pin <= 1'b0;
    cyc(6);
    rdc(8'h04, 32'h000);
    wr(8'h04, 32'h3);
    cyc(2);
    chk(gain_step, 10'h003);
    end_of_test();
  end
endmodule // cbl_control_tb
`default_nettype wire
